// [ruv_cfg.svh]
// constants for the residual overvoltage stages
// What this block does
// [RQ1] a stage starts whenever residual level exceeds its active threshold
// [RQ2] a stage trips when start has lasted longer than its delay
// [RQ3] two independent definite-time stages, low and high, own settings each
// [RQ4] each stage holds two setting groups, selected by input or manually
// [RQ5] group source is none, digital, virtual input, indicator or virtual output
// [RQ6] one shared force flag, cleared after five minutes without panel activity
// [RQ7] stage status test writes act only while the force flag is set
// [RQ8] each stage counts starts and trips; each counter clears on request
// [RQ9] stage status reads idle, blocked, start or trip
// [RQ10] settings and force writes need a prior valid password
// [RQ11] eight latest faults kept with timestamp, voltage, elapsed delay, group
// [RQ12] elapsed delay is percent of delay setting, 100 means trip
// [RQ13] timestamp holds calendar date and millisecond time of day
// [RQ14] levels, thresholds and fault voltage are percent of rated voltage
// [RQ15] single voltage measurement mode disables both stages
// [RQ16] only fundamental counts; third harmonic rejected by over 60 dB
// [RQ17] residual transformer scale maps samples to setting units
// [RQ18] level falling back below threshold drops start and restarts delay
`ifndef RUV_CFG_SVH
`define RUV_CFG_SVH
`define RUV_CLK_NS 10
`define RUV_TICK_NS 1000000
`define RUV_FORCE_MIN 5
`define RUV_MS_PER_MIN 60000
`define RUV_PCT_FULL 100
`define RUV_PCT_W 7
`define RUV_LEVEL_W 16
`define RUV_LOG_DEPTH 8
`define RUV_SAMPLES_CYC 12
`define RUV_H3_DIV 6
`define RUV_SCALE_SHIFT 8
`define RUV_IDX_LO 8
`define RUV_THR_LOW_RST 16'h000A
`define RUV_THR_HIGH_RST 16'h0028
`define RUV_DLY_LOW_RST 32'h000003E8
`define RUV_DLY_HIGH_RST 32'h000000C8
`endif

// [ruv_fault_log.sv]
// eight-entry record of the latest residual overvoltage faults
`timescale 1ns/10ps
`include "ruv_cfg.svh"
module ruv_fault_log
  import ruv_pkg::*;
#(
  parameter int DEPTH = `RUV_LOG_DEPTH
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wr,
  input wire logic wr_stage,
  input wire logic [31:0] wr_date,
  input wire logic [31:0] wr_time_ms,
  input wire logic [`RUV_LEVEL_W-1:0] wr_volt,
  input wire logic [`RUV_PCT_W-1:0] wr_ratio,
  input wire logic wr_group,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic rd_valid,
  output ruv_rec_t rd_rec
);
  localparam int AW = $clog2(DEPTH);
  ruv_rec_t mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW:0] fill_r;
  logic [AW-1:0] rd_addr;

  // newest entry is index 0; oldest is overwritten when full
  assign rd_addr = wr_ptr_r - AW'(1) - rd_idx;

  // [RQ11] keep latest eight
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr_r <= '0;
      fill_r <= '0;
    end
    else if (wr)
    begin
      wr_ptr_r <= wr_ptr_r + AW'(1);
      if (fill_r != (AW+1)'(DEPTH))
        fill_r <= fill_r + (AW+1)'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (wr)
      mem[wr_ptr_r] <= {wr_stage, wr_date, wr_time_ms, wr_volt, wr_ratio, wr_group};
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      rd_valid <= 1'b0;
      rd_rec <= '0;
    end
    else
    begin
      rd_valid <= ((AW+1)'(rd_idx) < fill_r);
      rd_rec <= mem[rd_addr];
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  log_fill_a: assert property (wr && fill_r < (AW+1)'(DEPTH) |=> fill_r == $past(fill_r) + (AW+1)'(1)) // [RQ11]
    else $error("fault log fill did not advance");
endmodule

// [ruv_pkg.sv]
// shared types of the residual overvoltage stages
`include "ruv_cfg.svh"
package ruv_pkg;
  typedef enum logic [1:0] {RUV_ST_IDLE, RUV_ST_BLOCKED, RUV_ST_START, RUV_ST_TRIP} ruv_status_t;
  typedef enum logic [2:0] {RUV_SRC_NONE, RUV_SRC_DI, RUV_SRC_VI, RUV_SRC_LED, RUV_SRC_VO} ruv_src_t;
  typedef enum logic [2:0]
  {
    RUV_IT_THR1, RUV_IT_THR2, RUV_IT_DLY1, RUV_IT_DLY2, RUV_IT_GROUP, RUV_IT_SRC, RUV_IT_FORCE
  } ruv_item_t;
  typedef enum logic [1:0] {RUV_SG_IDLE, RUV_SG_TIMING, RUV_SG_TRIPPED} ruv_stage_st_t;
  typedef struct packed {
    logic stage;
    logic [31:0] date;
    logic [31:0] time_ms;
    logic [`RUV_LEVEL_W-1:0] volt;
    logic [`RUV_PCT_W-1:0] ratio;
    logic group;
  } ruv_rec_t;
endpackage

// [ruv_stage.sv]
// one definite-time residual overvoltage stage
`timescale 1ns/10ps
`include "ruv_cfg.svh"
module ruv_stage
  import ruv_pkg::*;
#(
  parameter int LEVEL_W = `RUV_LEVEL_W
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic enable,
  input wire logic [LEVEL_W-1:0] level,
  input wire logic [LEVEL_W-1:0] threshold,
  input wire logic [31:0] delay_ms,
  output logic start,
  output logic trip,
  output logic [31:0] elapsed_ms
);
  ruv_stage_st_t state_r;
  logic above;
  logic trip_go;
  logic [31:0] elapsed_nxt;

  // [RQ1] compare level
  assign above = enable && (level > threshold);
  assign elapsed_nxt = elapsed_ms + 32'h00000001;
  // [RQ2] longer than delay
  assign trip_go = (state_r == RUV_SG_TIMING) && tick && (elapsed_nxt > delay_ms);

  // [RQ18] drop restarts
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      state_r <= RUV_SG_IDLE;
    else if (!above)
      state_r <= RUV_SG_IDLE;
    else
      case (state_r)
        RUV_SG_IDLE: state_r <= RUV_SG_TIMING;
        RUV_SG_TIMING: if (trip_go) state_r <= RUV_SG_TRIPPED;
        RUV_SG_TRIPPED: state_r <= RUV_SG_TRIPPED;
        default: state_r <= RUV_SG_IDLE;
      endcase
  end

  // delay counted in whole ticks, so the first tick may be partial
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      elapsed_ms <= 32'h00000000;
    else if (!above || state_r == RUV_SG_IDLE)
      elapsed_ms <= 32'h00000000;
    else if (state_r == RUV_SG_TIMING && tick)
      elapsed_ms <= elapsed_nxt;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      start <= 1'b0;
      trip <= 1'b0;
    end
    else
    begin
      start <= above;
      trip <= above && (state_r == RUV_SG_TRIPPED || trip_go);
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  start_cause_a: assert property ($rose(start) |-> $past(level) > $past(threshold)) // [RQ1]
    else $error("start rose without level above threshold");
  trip_delay_a: assert property ($rose(trip) |-> elapsed_ms > $past(delay_ms)) // [RQ2]
    else $error("trip before delay elapsed");
  disable_clear_a: assert property (!enable |=> !start && !trip && elapsed_ms == 32'h00000000) // [RQ18]
    else $error("stage active while disabled");
endmodule

// [ruv_top.sv]
// residual overvoltage protection: filter, settings, force, counters, fault capture
`timescale 1ns/10ps
`include "ruv_cfg.svh"
module ruv_top
  import ruv_pkg::*;
#(
  parameter int SAMPLE_W = 16,
  parameter int LEVEL_W = `RUV_LEVEL_W,
  parameter int CNT_W = 16,
  parameter int NIN = 8,
  parameter int SAMPLES_CYC = `RUV_SAMPLES_CYC,
  parameter int TICK_CYCLES = `RUV_TICK_NS / `RUV_CLK_NS,
  parameter int FORCE_MS = `RUV_FORCE_MIN * `RUV_MS_PER_MIN,
  // arbitrary value
  parameter logic [15:0] PASSWORD = 16'h2B4D
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sample_valid,
  input wire logic signed [SAMPLE_W-1:0] sample_data,
  input wire logic single_voltage_mode,
  input wire logic [15:0] residual_transformer_scale,
  input wire logic [1:0] stage_block,
  input wire logic [NIN-1:0] digital_input_n,
  input wire logic [NIN-1:0] virtual_input_n,
  input wire logic [NIN-1:0] indicator_signal_n,
  input wire logic [NIN-1:0] virtual_output_n,
  input wire logic [31:0] rtc_date,
  input wire logic [31:0] rtc_time_ms,
  input wire logic password_valid,
  input wire logic [15:0] password_value,
  input wire logic lock_req,
  input wire logic cfg_wr,
  input wire logic cfg_stage,
  input wire ruv_item_t cfg_item,
  input wire logic [31:0] cfg_data,
  input wire logic panel_activity,
  input wire logic test_wr,
  input wire logic test_stage,
  input wire ruv_status_t test_status,
  input wire logic count_clear,
  input wire logic count_stage,
  input wire logic count_kind,
  input wire logic [2:0] log_rd_idx,
  output logic [LEVEL_W-1:0] residual_voltage_level,
  output logic [1:0] start_out,
  output logic [1:0] trip_out,
  output ruv_status_t low_status,
  output ruv_status_t high_status,
  output logic [CNT_W-1:0] start_event_count_low,
  output logic [CNT_W-1:0] start_event_count_high,
  output logic [CNT_W-1:0] trip_event_count_low,
  output logic [CNT_W-1:0] trip_event_count_high,
  output logic [1:0] active_group_select,
  output logic force_flag,
  output logic unlocked,
  output logic log_valid,
  output logic log_stage,
  output logic [31:0] log_date,
  output logic [31:0] log_time_ms,
  output logic [LEVEL_W-1:0] log_voltage,
  output logic [`RUV_PCT_W-1:0] elapsed_delay_ratio,
  output logic log_group
);
  localparam int DLY = SAMPLES_CYC / `RUV_H3_DIV;
  localparam int PW = $clog2(SAMPLES_CYC);
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int FMW = $clog2(FORCE_MS);
  localparam int IW = $clog2(NIN);

  function automatic logic [SAMPLE_W:0] mag(input logic signed [SAMPLE_W:0] v);
    mag = (v < 0) ? -v : v;
  endfunction

  function automatic logic pick_group(input ruv_src_t src, input logic [IW-1:0] idx, input logic man);
    case (src)
      RUV_SRC_DI: pick_group = digital_input_n[idx];
      RUV_SRC_VI: pick_group = virtual_input_n[idx];
      RUV_SRC_LED: pick_group = indicator_signal_n[idx];
      RUV_SRC_VO: pick_group = virtual_output_n[idx];
      default: pick_group = man;
    endcase
  endfunction

  function automatic logic [`RUV_PCT_W-1:0] pct(input logic [31:0] el, input logic [31:0] dl);
    logic [39:0] q;
    q = 40'h0000000000;
    if (dl != 32'h00000000)
      q = ({8'h00, el} * 40'(`RUV_PCT_FULL)) / {8'h00, dl};
    if (dl == 32'h00000000 || q >= 40'(`RUV_PCT_FULL))
      pct = `RUV_PCT_W'(`RUV_PCT_FULL);
    else
      pct = q[`RUV_PCT_W-1:0];
  endfunction

  // [RQ16] third harmonic cancel
  // a sixth-cycle delayed sum nulls the third harmonic exactly; fundamental gain is sqrt(3)
  logic signed [SAMPLE_W-1:0] dl_r [DLY];
  logic signed [SAMPLE_W:0] comb_sum;
  logic [SAMPLE_W:0] comb_mag;
  logic [SAMPLE_W:0] peak_r;
  logic [SAMPLE_W:0] peak_hold_r;
  logic [SAMPLE_W:0] peak_nxt;
  logic [PW-1:0] phase_r;
  logic [SAMPLE_W+16:0] prod;
  logic [SAMPLE_W+16:0] scaled;
  logic [LEVEL_W-1:0] level_nxt;

  assign comb_sum = {sample_data[SAMPLE_W-1], sample_data} + {dl_r[DLY-1][SAMPLE_W-1], dl_r[DLY-1]};
  assign comb_mag = mag(comb_sum);
  assign peak_nxt = (comb_mag > peak_r) ? comb_mag : peak_r;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < DLY; i++)
        dl_r[i] <= '0;
      peak_r <= '0;
      peak_hold_r <= '0;
      phase_r <= '0;
    end
    else if (sample_valid)
    begin
      dl_r[0] <= sample_data;
      for (int i = 1; i < DLY; i++)
        dl_r[i] <= dl_r[i-1];
      if (phase_r == PW'(SAMPLES_CYC - 1))
      begin
        peak_hold_r <= peak_nxt;
        peak_r <= '0;
        phase_r <= '0;
      end
      else
      begin
        peak_r <= peak_nxt;
        phase_r <= phase_r + PW'(1);
      end
    end
  end

  // [RQ17] [RQ14] scale to percent
  assign prod = peak_hold_r * residual_transformer_scale;
  assign scaled = prod >> `RUV_SCALE_SHIFT;
  assign level_nxt = (scaled > (SAMPLE_W+17)'({LEVEL_W{1'b1}})) ? {LEVEL_W{1'b1}} : scaled[LEVEL_W-1:0];

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      residual_voltage_level <= '0;
    else
      residual_voltage_level <= level_nxt;
  end

  // millisecond tick for delays and the force timeout
  logic [TW-1:0] tick_cnt_r;
  logic tick_r;
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (tick_cnt_r == TW'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt_r + TW'(1);
    end
  end

  // [RQ10] password unlock
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      unlocked <= 1'b0;
    else if (password_valid && password_value == PASSWORD)
      unlocked <= 1'b1;
    else if (lock_req)
      unlocked <= 1'b0;
  end

  logic set_wr;
  assign set_wr = cfg_wr && unlocked;

  // [RQ3] [RQ4] per stage groups
  logic [LEVEL_W-1:0] thr_r [2][2];
  logic [31:0] dly_r [2][2];
  logic man_grp_r [2];
  ruv_src_t src_r [2];
  logic [IW-1:0] src_idx_r [2];
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int g = 0; g < 2; g++)
      begin
        thr_r[0][g] <= `RUV_THR_LOW_RST;
        thr_r[1][g] <= `RUV_THR_HIGH_RST;
        dly_r[0][g] <= `RUV_DLY_LOW_RST;
        dly_r[1][g] <= `RUV_DLY_HIGH_RST;
        man_grp_r[g] <= 1'b0;
        src_r[g] <= RUV_SRC_NONE;
        src_idx_r[g] <= '0;
      end
    end
    else if (set_wr)
      case (cfg_item)
        RUV_IT_THR1: thr_r[cfg_stage][0] <= cfg_data[LEVEL_W-1:0];
        RUV_IT_THR2: thr_r[cfg_stage][1] <= cfg_data[LEVEL_W-1:0];
        RUV_IT_DLY1: dly_r[cfg_stage][0] <= cfg_data;
        RUV_IT_DLY2: dly_r[cfg_stage][1] <= cfg_data;
        RUV_IT_GROUP: man_grp_r[cfg_stage] <= cfg_data[0];
        // [RQ5] source choice
        RUV_IT_SRC:
        begin
          if (cfg_data[2:0] <= RUV_SRC_VO)
          begin
            src_r[cfg_stage] <= ruv_src_t'(cfg_data[2:0]);
            src_idx_r[cfg_stage] <= cfg_data[`RUV_IDX_LO +: IW];
          end
        end
        default: ;
      endcase
  end

  logic grp_c [2];
  always_comb
  begin
    for (int s = 0; s < 2; s++)
      grp_c[s] = pick_group(src_r[s], src_idx_r[s], man_grp_r[s]);
  end

  // [RQ6] force with timeout
  logic [FMW-1:0] force_ms_r;
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      force_flag <= 1'b0;
      force_ms_r <= '0;
    end
    else if (set_wr && cfg_item == RUV_IT_FORCE)
    begin
      force_flag <= cfg_data[0];
      force_ms_r <= '0;
    end
    else if (panel_activity)
      force_ms_r <= '0;
    else if (force_flag && tick_r)
    begin
      if (force_ms_r == FMW'(FORCE_MS - 1))
      begin
        force_flag <= 1'b0;
        force_ms_r <= '0;
      end
      else
        force_ms_r <= force_ms_r + FMW'(1);
    end
  end

  // [RQ7] test status writes
  logic forced_act_r [2];
  ruv_status_t forced_st_r [2];
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      for (int s = 0; s < 2; s++)
      begin
        forced_act_r[s] <= 1'b0;
        forced_st_r[s] <= RUV_ST_IDLE;
      end
    else if (!force_flag)
      for (int s = 0; s < 2; s++)
        forced_act_r[s] <= 1'b0;
    else if (test_wr)
    begin
      forced_act_r[test_stage] <= 1'b1;
      forced_st_r[test_stage] <= test_status;
    end
  end

  logic [1:0] real_start;
  logic [1:0] real_trip;
  logic [31:0] elapsed [2];
  logic [1:0] blocked;
  genvar gs;
  generate
    for (gs = 0; gs < 2; gs++)
    begin : g_stage
      // [RQ15] mode disables
      assign blocked[gs] = single_voltage_mode || stage_block[gs];
      ruv_stage #(.LEVEL_W(LEVEL_W)) u_stage (
        .core_clk(core_clk),
        .reset(reset),
        .tick(tick_r),
        .enable(!blocked[gs]),
        .level(residual_voltage_level),
        .threshold(thr_r[gs][grp_c[gs]]),
        .delay_ms(dly_r[gs][grp_c[gs]]),
        .start(real_start[gs]),
        .trip(real_trip[gs]),
        .elapsed_ms(elapsed[gs])
      );
    end
  endgenerate

  // [RQ9] status value
  logic [1:0] eff_start;
  logic [1:0] eff_trip;
  ruv_status_t eff_st [2];
  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      if (forced_act_r[s])
      begin
        eff_st[s] = forced_st_r[s];
        eff_trip[s] = (forced_st_r[s] == RUV_ST_TRIP);
        eff_start[s] = eff_trip[s] || (forced_st_r[s] == RUV_ST_START);
      end
      else
      begin
        eff_start[s] = real_start[s];
        eff_trip[s] = real_trip[s];
        eff_st[s] = real_trip[s] ? RUV_ST_TRIP : real_start[s] ? RUV_ST_START :
          blocked[s] ? RUV_ST_BLOCKED : RUV_ST_IDLE;
      end
    end
  end

  logic [CNT_W-1:0] se_cnt_r [2];
  logic [CNT_W-1:0] te_cnt_r [2];
  ruv_status_t status_r [2];
  logic [1:0] start_rise;
  logic [1:0] trip_rise;
  assign start_rise = eff_start & ~start_out;
  assign trip_rise = eff_trip & ~trip_out;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      start_out <= 2'h0;
      trip_out <= 2'h0;
      active_group_select <= 2'h0;
      status_r[0] <= RUV_ST_IDLE;
      status_r[1] <= RUV_ST_IDLE;
    end
    else
    begin
      start_out <= eff_start;
      trip_out <= eff_trip;
      active_group_select <= {grp_c[1], grp_c[0]};
      status_r[0] <= eff_st[0];
      status_r[1] <= eff_st[1];
    end
  end
  assign low_status = status_r[0];
  assign high_status = status_r[1];

  // [RQ8] counters, a clear with a new event in the same cycle loads 1
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      for (int s = 0; s < 2; s++)
      begin
        se_cnt_r[s] <= '0;
        te_cnt_r[s] <= '0;
      end
    else
      for (int s = 0; s < 2; s++)
      begin
        if (start_rise[s])
          se_cnt_r[s] <= (count_clear && count_stage == s[0] && !count_kind) ? CNT_W'(1) : se_cnt_r[s] + CNT_W'(1);
        else if (count_clear && count_stage == s[0] && !count_kind)
          se_cnt_r[s] <= '0;
        if (trip_rise[s])
          te_cnt_r[s] <= (count_clear && count_stage == s[0] && count_kind) ? CNT_W'(1) : te_cnt_r[s] + CNT_W'(1);
        else if (count_clear && count_stage == s[0] && count_kind)
          te_cnt_r[s] <= '0;
      end
  end
  assign start_event_count_low = se_cnt_r[0];
  assign start_event_count_high = se_cnt_r[1];
  assign trip_event_count_low = te_cnt_r[0];
  assign trip_event_count_high = te_cnt_r[1];

  // [RQ11] [RQ12] fault capture at start fall
  logic [1:0] prev_start_r;
  logic [LEVEL_W-1:0] fmax_r [2];
  logic [31:0] fel_r [2];
  logic [1:0] ftrip_r;
  logic [1:0] fgrp_r;
  logic hi_pend_r;
  logic [1:0] fall;
  logic wr_sel;
  logic log_wr;
  assign fall = prev_start_r & ~real_start;
  assign log_wr = fall[0] || fall[1] || hi_pend_r;
  assign wr_sel = !fall[0];

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      prev_start_r <= 2'h0;
      ftrip_r <= 2'h0;
      fgrp_r <= 2'h0;
      hi_pend_r <= 1'b0;
      for (int s = 0; s < 2; s++)
      begin
        fmax_r[s] <= '0;
        fel_r[s] <= '0;
      end
    end
    else
    begin
      prev_start_r <= real_start;
      // both ending together: high is written one cycle after low
      hi_pend_r <= fall[0] && fall[1];
      for (int s = 0; s < 2; s++)
        if (real_start[s])
        begin
          fel_r[s] <= elapsed[s];
          fgrp_r[s] <= grp_c[s];
          if (!prev_start_r[s])
          begin
            fmax_r[s] <= residual_voltage_level;
            ftrip_r[s] <= real_trip[s];
          end
          else
          begin
            fmax_r[s] <= (residual_voltage_level > fmax_r[s]) ? residual_voltage_level : fmax_r[s];
            ftrip_r[s] <= ftrip_r[s] || real_trip[s];
          end
        end
    end
  end

  ruv_rec_t rec;
  ruv_fault_log u_log (
    .core_clk(core_clk),
    .reset(reset),
    .wr(log_wr),
    .wr_stage(wr_sel),
    // [RQ13] date and ms time
    .wr_date(rtc_date),
    .wr_time_ms(rtc_time_ms),
    .wr_volt(fmax_r[wr_sel]),
    .wr_ratio(ftrip_r[wr_sel] ? `RUV_PCT_W'(`RUV_PCT_FULL) : pct(fel_r[wr_sel], dly_r[wr_sel][fgrp_r[wr_sel]])),
    .wr_group(fgrp_r[wr_sel]),
    .rd_idx(log_rd_idx),
    .rd_valid(log_valid),
    .rd_rec(rec)
  );
  assign log_stage = rec.stage;
  assign log_date = rec.date;
  assign log_time_ms = rec.time_ms;
  assign log_voltage = rec.volt;
  assign elapsed_delay_ratio = rec.ratio;
  assign log_group = rec.group;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  locked_write_a: assert property (cfg_wr && !unlocked |=> $stable(thr_r[0][0]) && $stable(dly_r[1][1])) // [RQ10]
    else $error("setting changed while locked");
  force_gate_a: assert property (!force_flag && test_wr |=> !forced_act_r[0] && !forced_act_r[1]) // [RQ7]
    else $error("test status accepted without force");
  force_timeout_a: assert property ($fell(force_flag) && !$past(cfg_wr) |-> $past(force_ms_r) == FMW'(FORCE_MS - 1)) // [RQ6]
    else $error("force dropped before timeout");
  blocked_show_a: assert property (single_voltage_mode [*2] ##0 !forced_act_r[0] |=> status_r[0] == RUV_ST_BLOCKED) // [RQ15]
    else $error("stage not blocked in single voltage mode");
  count_clear_a: assert property (count_clear && !count_stage && !count_kind && !start_rise[0] |=> se_cnt_r[0] == '0) // [RQ8]
    else $error("start counter not cleared");
  count_step_a: assert property (trip_rise[1] && !count_clear |=> te_cnt_r[1] == $past(te_cnt_r[1]) + CNT_W'(1)) // [RQ8]
    else $error("trip counter did not count");
endmodule

// [ruv_vt_model.sv]
// voltage transformer front end model: 12 samples per power cycle
`timescale 1ns/10ps
module ruv_vt_model
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [15:0] amp,
  input wire logic h3,
  output logic sample_valid,
  output logic signed [15:0] sample_data
);
  logic [5:0] cnt_r;
  logic [3:0] ph;
  logic signed [15:0] val;
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      cnt_r <= 6'h00;
    else
      cnt_r <= (cnt_r == 6'h2F) ? 6'h00 : cnt_r + 6'h01;
  end
  assign ph = cnt_r[5:2];
  // h3 gives a period of four samples, the third harmonic of the power cycle
  assign val = (h3 ? ph[1] : (ph > 4'h5)) ? -$signed(amp) : $signed(amp);
  assign sample_valid = (cnt_r[1:0] == 2'h3);
  // off-strobe data is scrambled so a stale sample never looks valid
  assign sample_data = sample_valid ? val : ~val;
endmodule

// [tb_top.sv]
// self-checking bench for the residual overvoltage stages
`timescale 1ns/10ps
module tb_top;
  import ruv_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] amp = 16'h0000;
  logic h3 = 1'b0;
  logic single_mode = 1'b0;
  logic pw_valid = 1'b0;
  logic cfg_wr = 1'b0;
  logic test_wr = 1'b0;
  logic cnt_clr = 1'b0;
  logic [7:0] din = 8'h00;
  logic lock = 1'b0;
  logic panel = 1'b0;
  logic stg = 1'b0;
  logic kind = 1'b0;
  logic [1:0] blk = 2'h0;
  logic [2:0] ridx = 3'h0;
  logic [15:0] pw = 16'h0000;
  ruv_item_t cfg_item = RUV_IT_THR1;
  ruv_status_t test_status = RUV_ST_IDLE;
  logic [31:0] cfg_data = 32'h00000000;
  logic sample_valid;
  logic signed [15:0] sample_data;
  logic [15:0] level;
  logic [1:0] start_out;
  logic [1:0] trip_out;
  logic [1:0] grp;
  ruv_status_t low_status;
  ruv_status_t hst;
  logic [15:0] scnt;
  logic [15:0] tcnt;
  logic [15:0] scnt_h;
  logic [15:0] tcnt_h;
  logic lstg;
  logic lgrp;
  logic [31:0] ltime;
  logic force_flag;
  logic unlocked;
  logic log_valid;
  logic [31:0] log_date;
  logic [15:0] log_voltage;
  logic [6:0] ratio;
  int failures = 0;
  int tests_run = 0;
  always #5 core_clk = ~core_clk;
  ruv_vt_model vt (.core_clk(core_clk), .reset(reset), .amp(amp), .h3(h3), .sample_valid(sample_valid),
    .sample_data(sample_data));
  ruv_top #(.TICK_CYCLES(10), .FORCE_MS(20)) dut (.core_clk(core_clk), .reset(reset),
    .sample_valid(sample_valid), .sample_data(sample_data), .single_voltage_mode(single_mode),
    .residual_transformer_scale(16'h0080), .stage_block(blk), .digital_input_n(din),
    .virtual_input_n(din), .indicator_signal_n(din), .virtual_output_n(din), .rtc_date(32'h07E80305),
    .rtc_time_ms(32'h00001234), .password_valid(pw_valid), .password_value(pw), .lock_req(lock),
    .cfg_wr(cfg_wr), .cfg_stage(stg), .cfg_item(cfg_item), .cfg_data(cfg_data), .panel_activity(panel),
    .test_wr(test_wr), .test_stage(stg), .test_status(test_status), .count_clear(cnt_clr),
    .count_stage(stg), .count_kind(kind), .log_rd_idx(ridx), .residual_voltage_level(level),
    .start_out(start_out), .trip_out(trip_out), .low_status(low_status), .high_status(hst),
    .start_event_count_low(scnt), .start_event_count_high(scnt_h), .trip_event_count_low(tcnt),
    .trip_event_count_high(tcnt_h), .active_group_select(grp), .force_flag(force_flag), .unlocked(unlocked),
    .log_valid(log_valid), .log_stage(lstg), .log_date(log_date), .log_time_ms(ltime), .log_voltage(log_voltage),
    .elapsed_delay_ratio(ratio), .log_group(lgrp));
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cfg(input ruv_item_t it, input logic [31:0] d);
    cfg_item = it;
    cfg_data = d;
    cfg_wr = 1'b1;
    settle(1);
    cfg_wr = 1'b0;
    settle(1);
  endtask
  task automatic unlock(input logic [15:0] v);
    pw = v;
    pw_valid = 1'b1;
    settle(1);
    pw_valid = 1'b0;
  endtask
  task print_verdict;
    if (failures == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    settle(2);
    reset = 1'b0;
    chk(low_status, RUV_ST_IDLE);
    cfg(RUV_IT_THR1, 32'h00000005);
    amp = 16'h0008;
    settle(120);
    chk(level, 32'h8);
    chk(start_out, 32'h0);
    unlock(16'h0000);
    chk(unlocked, 32'h0);
    unlock(16'h2B4D);
    chk(unlocked, 32'h1);
    cfg(RUV_IT_THR1, 32'h00000014);
    cfg(RUV_IT_DLY1, 32'h00000014);
    amp = 16'h001E;
    settle(120);
    chk(start_out, 32'h1);
    chk(trip_out, 32'h0);
    settle(250);
    chk(trip_out, 32'h1);
    chk(low_status, RUV_ST_TRIP);
    chk({scnt, tcnt}, 32'h00010001);
    amp = 16'h0000;
    settle(120);
    chk(start_out, 32'h0);
    chk({log_valid, ratio}, 32'hE4);
    chk(log_voltage, 32'h1E);
    chk(log_date, 32'h07E80305);
    chk({lstg, lgrp, ltime[29:0]}, 32'h00001234);
    ridx = 3'h1;
    settle(2);
    chk(log_valid, 32'h0);
    h3 = 1'b1;
    amp = 16'h001E;
    settle(120);
    chk(level, 32'h0);
    h3 = 1'b0;
    single_mode = 1'b1;
    settle(120);
    chk({start_out, low_status}, {28'h0, 2'h0, RUV_ST_BLOCKED});
    single_mode = 1'b0;
    blk = 2'h1;
    settle(4);
    chk({start_out, low_status}, {28'h0, 2'h0, RUV_ST_BLOCKED});
    // level must decay before the stage is released, or it starts again
    amp = 16'h0000;
    settle(120);
    blk = 2'h0;
    cnt_clr = 1'b1;
    settle(1);
    cnt_clr = 1'b0;
    settle(1);
    chk({scnt, tcnt}, 32'h00000001);
    kind = 1'b1;
    cnt_clr = 1'b1;
    settle(1);
    cnt_clr = 1'b0;
    settle(1);
    chk(tcnt, 32'h0);
    test_status = RUV_ST_TRIP;
    test_wr = 1'b1;
    settle(1);
    test_wr = 1'b0;
    settle(3);
    chk(trip_out, 32'h0);
    cfg(RUV_IT_FORCE, 32'h00000001);
    test_wr = 1'b1;
    settle(1);
    test_wr = 1'b0;
    settle(3);
    chk({force_flag, trip_out}, 32'h5);
    stg = 1'b1;
    test_wr = 1'b1;
    settle(1);
    test_wr = 1'b0;
    stg = 1'b0;
    settle(3);
    chk({hst, trip_out}, 32'hF);
    settle(140);
    panel = 1'b1;
    settle(1);
    panel = 1'b0;
    settle(150);
    chk({force_flag, trip_out}, 32'h7);
    chk({scnt_h, tcnt_h}, 32'h00010001);
    settle(100);
    chk({force_flag, trip_out}, 32'h0);
    cfg(RUV_IT_GROUP, 32'h00000001);
    chk(grp, 32'h1);
    cfg(RUV_IT_SRC, 32'h00000201);
    din = 8'h04;
    settle(4);
    chk(grp, 32'h1);
    din = 8'h00;
    settle(4);
    chk(grp, 32'h0);
    lock = 1'b1;
    settle(1);
    lock = 1'b0;
    cfg(RUV_IT_SRC, 32'h00000000);
    chk({unlocked, grp}, 32'h0);
    print_verdict;
  end
  initial
  begin
    settle(20000);
    failures++;
    print_verdict;
  end
endmodule
